/* amcb_bank.sv */
// misc configuration and status register bank of the amplifier
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "amcb_regs.svh"

// What this block does
// - bits 6-5 select loop bandwidth 80/100/120/175 kHz, reset 00.
// - five-bit attenuation in 0.5 dB steps, 0 to -15.5 dB; top bits reserved.
// - bit 0 at 5Ch marks start of a biquad's first coefficient write.
// - bit 7 picks converter clock 6.144 MHz at 0, 3.072 MHz at 1.
// - dither enable field chooses none, main, second or both stages, reset 11.
// - dither level field selects documented levels, reset 110.
// - element matching enabled for 00, disabled for 11, reset 00.
// - bit 0 at 60h makes multipurpose pin input at 0, output at 1.
// - pin function drives low, both-mute, left-mute or right-mute flags.
// - code 00110 gives clock invalid, 01011 active-low fault output.
// - bypass bit 3 gives separate coefficients; 0 shares left coefficients.
// - bypass bit 2 bypasses the 128-tap FIR stage.
// - bypass bit 1 bypasses range compression in left and right paths.
// - bypass bit 0 bypasses equalisers in left and right paths.
// - state report at 68h returns 0 deep sleep to 3 play.
// - a channel auto-mutes after a run of zero samples, shortest 11.5 ms.
module amcb_bank
    import amcb_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic sample_strobe_in,
    input wire logic left_zero_in,
    input wire logic right_zero_in,
    input wire logic clk_invalid_in,
    input wire logic fault_in,
    input wire logic [1:0] op_state_in,
    input wire logic [7:0] silicon_id_in,
    input wire logic addr_pin_in,
    output logic addr_pin_out,
    output logic addr_pin_oe_out,
    output logic addr_pin_level_out,
    output amcb_cfg_s cfg_out,
    output logic [1:0] mute_out
);
    localparam int MUTE_SAMPLES = `AMCB_MUTE_SAMPLES;

    logic rst_meta_reg, rst_sync_reg;
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    wire logic rst_b = rst_sync_reg;

    // pin-side inputs come from other domains: two flops each
    logic [5:0] in_meta_reg, in_sync_reg;
    always_ff @(posedge ref_clk_in or negedge rst_b) begin
        if (!rst_b) begin
            in_meta_reg <= 6'h00;
            in_sync_reg <= 6'h00;
        end else begin
            in_meta_reg <= {addr_pin_in, sample_strobe_in, left_zero_in, right_zero_in,
                clk_invalid_in, fault_in};
            in_sync_reg <= in_meta_reg;
        end
    end
    wire logic pin_lvl = in_sync_reg[5];
    wire logic smp = in_sync_reg[4];
    wire logic zl = in_sync_reg[3];
    wire logic zr = in_sync_reg[2];
    wire logic clk_bad = in_sync_reg[1];
    wire logic fault = in_sync_reg[0];

    // register storage
    logic [7:0] bw_reg, bw_next, gain_reg, gain_next, bq_reg, bq_next;
    logic [7:0] conv_reg, conv_next, dir_reg, dir_next, func_reg, func_next;
    logic [7:0] byp_reg, byp_next, rdata_reg, rdata_next;
    amcb_bus_req_s req;
    assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

    always_comb begin
        bw_next = bw_reg;
        gain_next = gain_reg;
        bq_next = bq_reg;
        conv_next = conv_reg;
        dir_next = dir_reg;
        func_next = func_reg;
        byp_next = byp_reg;
        // each register loads alone; all bits stored so reserved bits read back
        if (req.wr) begin
            if (req.addr == `AMCB_OFF_BANDWIDTH) begin
                bw_next = req.wdata;
            end else if (req.addr == `AMCB_OFF_GAIN) begin
                gain_next = req.wdata;
            end else if (req.addr == `AMCB_OFF_BIQUAD_WR) begin
                bq_next = req.wdata;
            end else if (req.addr == `AMCB_OFF_CONVERTER) begin
                conv_next = req.wdata;
            end else if (req.addr == `AMCB_OFF_PIN_DIR) begin
                dir_next = req.wdata;
            end else if (req.addr == `AMCB_OFF_PIN_FUNC) begin
                func_next = req.wdata;
            end else if (req.addr == `AMCB_OFF_BYPASS) begin
                byp_next = req.wdata;
            end
        end
    end

    amcb_state_e op_state;
    always_comb begin
        case (op_state_in)
            2'd0: op_state = AMCB_DEEP_SLEEP;
            2'd1: op_state = AMCB_SLEEP;
            2'd2: op_state = AMCB_OUTPUTS_FLOATING;
            default: op_state = AMCB_PLAY;
        endcase
    end

    function automatic logic [7:0] state_code(input amcb_state_e s);
        case (s)
            AMCB_DEEP_SLEEP: state_code = 8'h00;
            AMCB_SLEEP: state_code = 8'h01;
            AMCB_OUTPUTS_FLOATING: state_code = 8'h02;
            default: state_code = 8'h03;
        endcase
    endfunction

    always_comb begin
        rdata_next = 8'h00;
        if (req.rd) begin
            if (req.addr == `AMCB_OFF_BANDWIDTH) begin
                rdata_next = bw_reg;
            end else if (req.addr == `AMCB_OFF_GAIN) begin
                rdata_next = gain_reg;
            end else if (req.addr == `AMCB_OFF_BIQUAD_WR) begin
                rdata_next = bq_reg;
            end else if (req.addr == `AMCB_OFF_CONVERTER) begin
                rdata_next = conv_reg;
            end else if (req.addr == `AMCB_OFF_PIN_DIR) begin
                rdata_next = dir_reg;
            end else if (req.addr == `AMCB_OFF_PIN_FUNC) begin
                rdata_next = func_reg;
            end else if (req.addr == `AMCB_OFF_BYPASS) begin
                rdata_next = byp_reg;
            end else if (req.addr == `AMCB_OFF_SILICON_ID) begin
                rdata_next = silicon_id_in;
            end else if (req.addr == `AMCB_OFF_OPERATING_STATE_CODE) begin
                rdata_next = state_code(op_state);
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b) begin
        if (!rst_b) begin
            bw_reg <= `AMCB_RST_BANDWIDTH;
            gain_reg <= `AMCB_RST_GAIN;
            bq_reg <= `AMCB_RST_BIQUAD_WR;
            conv_reg <= `AMCB_RST_CONVERTER;
            dir_reg <= `AMCB_RST_PIN_DIR;
            func_reg <= `AMCB_RST_PIN_FUNC;
            byp_reg <= `AMCB_RST_BYPASS;
            rdata_reg <= 8'h00;
        end else begin
            bw_reg <= bw_next;
            gain_reg <= gain_next;
            bq_reg <= bq_next;
            conv_reg <= conv_next;
            dir_reg <= dir_next;
            func_reg <= func_next;
            byp_reg <= byp_next;
            rdata_reg <= rdata_next;
        end
    end
    assign rdata_out = rdata_reg;

    // zero-run counters, one per channel; a non-zero sample restarts the run
    logic [15:0] run_l_reg, run_l_next, run_r_reg, run_r_next;
    logic smp_d_reg;
    logic [1:0] mute_reg, mute_next;
    wire logic smp_rise = smp & ~smp_d_reg;
    always_comb begin
        run_l_next = run_l_reg;
        run_r_next = run_r_reg;
        if (smp_rise) begin
            run_l_next = !zl ? 16'h0000 :
                (run_l_reg == 16'(MUTE_SAMPLES)) ? run_l_reg : run_l_reg + 16'h0001;
            run_r_next = !zr ? 16'h0000 :
                (run_r_reg == 16'(MUTE_SAMPLES)) ? run_r_reg : run_r_reg + 16'h0001;
        end
        mute_next = {run_r_next == 16'(MUTE_SAMPLES), run_l_next == 16'(MUTE_SAMPLES)};
    end

    // pin function and direction
    logic pin_o_next, pin_oe_next;
    amcb_cfg_s cfg_next, cfg_reg;
    // converter fields start at their register reset so decoded outputs agree at release
    localparam amcb_cfg_s CFG_RST = '{conv_half_rate: 1'h1, dither_enable: 2'h3,
        dither_level: 3'h6, dem_enable: 1'h1, default: '0};
    logic pin_o_reg, pin_oe_reg, pin_lvl_reg;
    always_comb begin
        case (func_reg[`AMCB_PIN_FUNC_HI:0])
            `AMCB_FUNC_MUTE_BOTH: pin_o_next = mute_reg[0] & mute_reg[1];
            `AMCB_FUNC_MUTE_LEFT: pin_o_next = mute_reg[0];
            `AMCB_FUNC_MUTE_RIGHT: pin_o_next = mute_reg[1];
            `AMCB_FUNC_CLK_INVALID: pin_o_next = clk_bad;
            `AMCB_FUNC_FAULT_N: pin_o_next = ~fault;
            default: pin_o_next = 1'b0;
        endcase
        pin_oe_next = dir_reg[0];
        cfg_next.loop_bandwidth_sel = bw_reg[`AMCB_BW_HI:`AMCB_BW_LO];
        cfg_next.analog_attenuation = gain_reg[`AMCB_GAIN_HI:0];
        cfg_next.filter_first_coef_marker = bq_reg[0];
        cfg_next.conv_half_rate = conv_reg[`AMCB_CONV_FREQ_BIT];
        cfg_next.dither_enable = conv_reg[`AMCB_DITHER_EN_HI:`AMCB_DITHER_EN_LO];
        cfg_next.dither_level = conv_reg[`AMCB_DITHER_LVL_HI:`AMCB_DITHER_LVL_LO];
        cfg_next.element_matching_sel = conv_reg[`AMCB_DEM_HI:0];
        cfg_next.dem_enable = conv_reg[`AMCB_DEM_HI:0] != 2'b11;
        cfg_next.separate_coef = byp_reg[3];
        cfg_next.fir_bypass = byp_reg[2];
        cfg_next.range_compressor_bypass = byp_reg[1];
        cfg_next.eq_bypass = byp_reg[0];
    end

    always_ff @(posedge ref_clk_in or negedge rst_b) begin
        if (!rst_b) begin
            run_l_reg <= 16'h0000;
            run_r_reg <= 16'h0000;
            smp_d_reg <= 1'b0;
            mute_reg <= 2'b00;
            pin_o_reg <= 1'b0;
            pin_oe_reg <= 1'b0;
            pin_lvl_reg <= 1'b0;
            cfg_reg <= CFG_RST;
        end else begin
            run_l_reg <= run_l_next;
            run_r_reg <= run_r_next;
            smp_d_reg <= smp;
            mute_reg <= mute_next;
            pin_o_reg <= pin_o_next;
            pin_oe_reg <= pin_oe_next;
            pin_lvl_reg <= pin_lvl;
            cfg_reg <= cfg_next;
        end
    end
    assign addr_pin_out = pin_o_reg;
    assign addr_pin_oe_out = pin_oe_reg;
    assign addr_pin_level_out = pin_lvl_reg;
    assign cfg_out = cfg_reg;
    assign mute_out = mute_reg;

    sequence bw_write_s;
        wr_in && addr_in == `AMCB_OFF_BANDWIDTH;
    endsequence
    bw_apply_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b)
        bw_write_s |-> ##2 cfg_out.loop_bandwidth_sel == $past(wdata_in[6:5], 2))
        else $error("bandwidth field not applied");
    sequence gain_write_s;
        wr_in && addr_in == `AMCB_OFF_GAIN;
    endsequence
    gain_apply_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b)
        gain_write_s |-> ##2 cfg_out.analog_attenuation == $past(wdata_in[4:0], 2))
        else $error("attenuation not applied");
    sequence conv_write_s;
        wr_in && addr_in == `AMCB_OFF_CONVERTER;
    endsequence
    conv_rate_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b)
        conv_write_s |-> ##2 cfg_out.conv_half_rate == $past(wdata_in[7], 2))
        else $error("converter rate not applied");
    dither_en_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b)
        conv_write_s |-> ##2 cfg_out.dither_enable == $past(wdata_in[6:5], 2))
        else $error("dither enable not applied");
    dither_lvl_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b)
        conv_write_s |-> ##2 cfg_out.dither_level == $past(wdata_in[4:2], 2))
        else $error("dither level not applied");
    dem_map_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b)
        cfg_out.dem_enable == ($past(conv_reg[`AMCB_DEM_HI:0]) != 2'h3))
        else $error("element matching decode wrong");
    pin_dir_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b)
        addr_pin_oe_out == $past(dir_reg[0]))
        else $error("pin direction wrong");
    pin_low_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b)
        $past(func_reg[4:0]) == `AMCB_FUNC_LOW |-> !addr_pin_out)
        else $error("pin not low for function zero");
    fault_pin_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b)
        $past(func_reg[4:0]) == `AMCB_FUNC_FAULT_N |-> addr_pin_out == !$past(fault))
        else $error("fault output not active low");
    state_read_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b)
        rd_in && addr_in == `AMCB_OFF_OPERATING_STATE_CODE |=> rdata_out == {6'h00, $past(op_state_in)})
        else $error("state report wrong");
    readback_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b)
        wr_in && addr_in == `AMCB_OFF_BYPASS ##1 rd_in && addr_in == `AMCB_OFF_BYPASS
        |=> rdata_out == $past(wdata_in, 2))
        else $error("bypass readback wrong");
    mute_hold_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b)
        mute_out[0] |-> run_l_reg == 16'(MUTE_SAMPLES))
        else $error("left mute without full zero run");

    sequence byp_write_s;
        wr_in && addr_in == `AMCB_OFF_BYPASS;
    endsequence
    sep_coef_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b)
        byp_write_s |-> ##2 cfg_out.separate_coef == $past(wdata_in[3], 2))
        else $error("coefficient sharing not applied");
    fir_bypass_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b)
        byp_write_s |-> ##2 cfg_out.fir_bypass == $past(wdata_in[2], 2))
        else $error("fir bypass not applied");
    comp_bypass_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b)
        byp_write_s |-> ##2 cfg_out.range_compressor_bypass == $past(wdata_in[1], 2))
        else $error("compressor bypass not applied");
    eq_bypass_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b)
        byp_write_s |-> ##2 cfg_out.eq_bypass == $past(wdata_in[0], 2))
        else $error("equaliser bypass not applied");

    sequence bq_write_s;
        wr_in && addr_in == `AMCB_OFF_BIQUAD_WR;
    endsequence
    coef_marker_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b)
        bq_write_s |-> ##2 cfg_out.filter_first_coef_marker == $past(wdata_in[0], 2))
        else $error("first coefficient marker not applied");

    both_pin_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b)
        $past(func_reg[4:0]) == `AMCB_FUNC_MUTE_BOTH |-> addr_pin_out == ($past(mute_out) == 2'h3))
        else $error("both-mute flag wrong");
    left_pin_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b)
        $past(func_reg[4:0]) == `AMCB_FUNC_MUTE_LEFT |-> addr_pin_out == $past(mute_out[0]))
        else $error("left mute flag wrong");
    right_pin_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b)
        $past(func_reg[4:0]) == `AMCB_FUNC_MUTE_RIGHT |-> addr_pin_out == $past(mute_out[1]))
        else $error("right mute flag wrong");
    clk_flag_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b)
        $past(func_reg[4:0]) == `AMCB_FUNC_CLK_INVALID |-> addr_pin_out == $past(clk_bad))
        else $error("clock invalid flag wrong");

    right_hold_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b)
        mute_out[1] |-> run_r_reg == 16'(MUTE_SAMPLES))
        else $error("right mute without full zero run");
    run_break_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b)
        smp_rise && !zl |=> !mute_out[0])
        else $error("left mute kept after non-zero sample");
endmodule

/* amcb_regs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef AMCB_REGS_SVH
`define AMCB_REGS_SVH

`define AMCB_OFF_BANDWIDTH 8'h53
`define AMCB_OFF_GAIN 8'h54
`define AMCB_OFF_BIQUAD_WR 8'h5C
`define AMCB_OFF_CONVERTER 8'h5D
`define AMCB_OFF_PIN_DIR 8'h60
`define AMCB_OFF_PIN_FUNC 8'h61
`define AMCB_OFF_BYPASS 8'h66
`define AMCB_OFF_SILICON_ID 8'h67
`define AMCB_OFF_OPERATING_STATE_CODE 8'h68

`define AMCB_RST_BANDWIDTH 8'h00
`define AMCB_RST_GAIN 8'h00
`define AMCB_RST_BIQUAD_WR 8'h00
`define AMCB_RST_CONVERTER 8'hF8
`define AMCB_RST_PIN_DIR 8'h00
`define AMCB_RST_PIN_FUNC 8'h00
`define AMCB_RST_BYPASS 8'h00

`define AMCB_BW_HI 6
`define AMCB_BW_LO 5
`define AMCB_GAIN_HI 4
`define AMCB_CONV_FREQ_BIT 7
`define AMCB_DITHER_EN_HI 6
`define AMCB_DITHER_EN_LO 5
`define AMCB_DITHER_LVL_HI 4
`define AMCB_DITHER_LVL_LO 2
`define AMCB_DEM_HI 1
`define AMCB_PIN_FUNC_HI 4

`define AMCB_FUNC_LOW 5'h00
`define AMCB_FUNC_MUTE_BOTH 5'h03
`define AMCB_FUNC_MUTE_LEFT 5'h04
`define AMCB_FUNC_MUTE_RIGHT 5'h05
`define AMCB_FUNC_CLK_INVALID 5'h06
`define AMCB_FUNC_FAULT_N 5'h0B

// mute timing: shortest run is 11.5 ms, counted in samples at the 96 kHz rate
`define AMCB_MUTE_TIME_US 11500
`define AMCB_SAMPLE_RATE_HZ 96000
`define AMCB_MUTE_SAMPLES ((`AMCB_MUTE_TIME_US * `AMCB_SAMPLE_RATE_HZ) / 1000000)
// converter rates as dividers of the 40 MHz clock are not integral; strobes only
`define AMCB_CLK_HZ 40000000

`endif

/* amcb_pkg.sv */
// types shared by the configuration bank
package amcb_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } amcb_bus_req_s;

    typedef struct packed {
        logic [1:0] loop_bandwidth_sel;
        logic [4:0] analog_attenuation;
        logic filter_first_coef_marker;
        logic conv_half_rate;
        logic [1:0] dither_enable;
        logic [2:0] dither_level;
        logic [1:0] element_matching_sel;
        logic dem_enable;
        logic separate_coef;
        logic fir_bypass;
        logic range_compressor_bypass;
        logic eq_bypass;
    } amcb_cfg_s;

    typedef enum logic [3:0] {
        AMCB_DEEP_SLEEP = 4'b0001,
        AMCB_SLEEP = 4'b0010,
        AMCB_OUTPUTS_FLOATING = 4'b0100,
        AMCB_PLAY = 4'b1000
    } amcb_state_e;
endpackage

/* amp_misc_config_bank_test.sv */
// self-checking bench for the misc configuration register bank
`timescale 1ns/1ps
`include "amcb_regs.svh"
module amp_misc_config_bank_test
    import amcb_pkg::*;
;
    logic ref_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic sample_strobe_in = 1'b0;
    logic left_zero_in = 1'b0;
    logic right_zero_in = 1'b0;
    logic clk_invalid_in = 1'b0;
    logic fault_in = 1'b0;
    logic addr_pin_in = 1'b0;
    logic [1:0] op_state_in = 2'b00;
    // arbitrary identifier value
    logic [7:0] silicon_id_in = 8'h5a;
    logic [7:0] rdata_out;
    logic addr_pin_out;
    logic addr_pin_oe_out;
    logic addr_pin_level_out;
    amcb_cfg_s cfg_out;
    logic [1:0] mute_out;
    int bad_count = 0;
    int samples_checked = 0;
    // covers both converter rates and every dither enable code
    logic [7:0] conv_vals [4] = '{8'h7b, 8'h86, 8'hd1, 8'h2e};

    amcb_bank DUT (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .sample_strobe_in(sample_strobe_in), .left_zero_in(left_zero_in),
        .right_zero_in(right_zero_in), .clk_invalid_in(clk_invalid_in),
        .fault_in(fault_in), .op_state_in(op_state_in), .silicon_id_in(silicon_id_in),
        .addr_pin_in(addr_pin_in), .addr_pin_out(addr_pin_out),
        .addr_pin_oe_out(addr_pin_oe_out), .addr_pin_level_out(addr_pin_level_out),
        .cfg_out(cfg_out), .mute_out(mute_out));

    always #12.5 ref_clk_in = ~ref_clk_in;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // outputs are looked at on the falling edge, well clear of updates
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        @(negedge ref_clk_in);
        check(rdata_out, e);
    endtask

    // write then read back with no gap, as the bus allows
    task automatic wr_rd_check(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
        rd_in <= 1'b1;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        @(negedge ref_clk_in);
        check(rdata_out, d);
    endtask

    // strobe held high three cycles so the two-flop sync sees every rise
    task automatic sample(input logic lz, input logic rz);
        @(posedge ref_clk_in);
        left_zero_in <= lz;
        right_zero_in <= rz;
        sample_strobe_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        sample_strobe_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
    endtask

    task automatic test_reset_values();
        rd_check(`AMCB_OFF_BANDWIDTH, 8'h00);
        rd_check(`AMCB_OFF_GAIN, 8'h00);
        rd_check(`AMCB_OFF_BIQUAD_WR, 8'h00);
        rd_check(`AMCB_OFF_CONVERTER, 8'hf8);
        rd_check(`AMCB_OFF_PIN_DIR, 8'h00);
        rd_check(`AMCB_OFF_PIN_FUNC, 8'h00);
        rd_check(`AMCB_OFF_BYPASS, 8'h00);
        check({cfg_out.conv_half_rate, cfg_out.dither_enable, cfg_out.dither_level,
            cfg_out.element_matching_sel}, 8'hf8);
        check({6'h00, addr_pin_oe_out, addr_pin_out}, 8'h00);
        $display("test reset_values done");
    endtask

    task automatic test_config_fields();
        logic [7:0] v;
        for (int i = 0; i < 4; i++) begin
            wr(`AMCB_OFF_BANDWIDTH, {1'b1, i[1:0], 5'h15});
            settle(1);
            check({6'h00, cfg_out.loop_bandwidth_sel}, 8'(i));
            rd_check(`AMCB_OFF_BANDWIDTH, {1'b1, i[1:0], 5'h15});
            v = conv_vals[i];
            wr(`AMCB_OFF_CONVERTER, v);
            settle(1);
            check({cfg_out.conv_half_rate, cfg_out.dither_enable, cfg_out.dither_level,
                cfg_out.element_matching_sel}, v);
            check({7'h00, cfg_out.dem_enable}, {7'h00, v[1:0] != 2'b11});
        end
        for (int g = 0; g < 2; g++) begin
            v = (g == 0) ? 8'he1 : 8'h1f;
            wr(`AMCB_OFF_GAIN, v);
            settle(1);
            check({3'h0, cfg_out.analog_attenuation}, {3'h0, v[4:0]});
            rd_check(`AMCB_OFF_GAIN, v);
            wr(`AMCB_OFF_BIQUAD_WR, {v[7:1], 1'(g)});
            settle(1);
            check({7'h00, cfg_out.filter_first_coef_marker}, 8'(g));
        end
        for (int b = 0; b < 16; b++) begin
            wr(`AMCB_OFF_BYPASS, {4'ha, b[3:0]});
            settle(1);
            check({4'h0, cfg_out.separate_coef, cfg_out.fir_bypass,
                cfg_out.range_compressor_bypass, cfg_out.eq_bypass}, 8'(b));
        end
        rd_check(`AMCB_OFF_BYPASS, 8'haf);
        wr_rd_check(`AMCB_OFF_BYPASS, 8'h35);
        $display("test config_fields done");
    endtask

    task automatic test_read_only();
        wr(`AMCB_OFF_SILICON_ID, 8'hff);
        wr(`AMCB_OFF_OPERATING_STATE_CODE, 8'hff);
        wr(8'h55, 8'haa);
        rd_check(`AMCB_OFF_SILICON_ID, 8'h5a);
        rd_check(8'h55, 8'h00);
        rd_check(`AMCB_OFF_GAIN, 8'h1f);
        for (int s = 0; s < 4; s++) begin
            @(posedge ref_clk_in);
            op_state_in <= 2'(s);
            rd_check(`AMCB_OFF_OPERATING_STATE_CODE, 8'(s));
        end
        $display("test read_only done");
    endtask

    task automatic pin_func(input logic [4:0] f, input logic e);
        wr(`AMCB_OFF_PIN_FUNC, {3'b000, f});
        settle(5);
        check({7'h00, addr_pin_out}, {7'h00, e});
    endtask

    task automatic test_pin_and_mute();
        wr(`AMCB_OFF_PIN_DIR, 8'h01);
        settle(1);
        check({7'h00, addr_pin_oe_out}, 8'h01);
        @(posedge ref_clk_in);
        clk_invalid_in <= 1'b1;
        pin_func(`AMCB_FUNC_CLK_INVALID, 1'b1);
        @(posedge ref_clk_in);
        clk_invalid_in <= 1'b0;
        settle(5);
        check({7'h00, addr_pin_out}, 8'h00);
        pin_func(`AMCB_FUNC_FAULT_N, 1'b1);
        @(posedge ref_clk_in);
        fault_in <= 1'b1;
        settle(5);
        check({7'h00, addr_pin_out}, 8'h00);
        pin_func(`AMCB_FUNC_MUTE_BOTH, 1'b0);
        repeat (`AMCB_MUTE_SAMPLES - 1) sample(1'b1, 1'b1);
        settle(6);
        check({6'h00, mute_out}, 8'h00);
        sample(1'b1, 1'b1);
        settle(6);
        check({6'h00, mute_out}, 8'h03);
        settle(3);
        check({7'h00, addr_pin_out}, 8'h01);
        sample(1'b1, 1'b0);
        settle(6);
        check({6'h00, mute_out}, 8'h01);
        check({7'h00, addr_pin_out}, 8'h00);
        pin_func(`AMCB_FUNC_MUTE_LEFT, 1'b1);
        pin_func(`AMCB_FUNC_MUTE_RIGHT, 1'b0);
        pin_func(`AMCB_FUNC_MUTE_LEFT, 1'b1);
        pin_func(`AMCB_FUNC_LOW, 1'b0);
        wr(`AMCB_OFF_PIN_DIR, 8'h00);
        @(posedge ref_clk_in);
        addr_pin_in <= 1'b1;
        settle(5);
        check({6'h00, addr_pin_oe_out, addr_pin_level_out}, 8'h01);
        $display("test pin_and_mute done");
    endtask

    initial begin
        repeat (2) @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        test_reset_values();
        test_config_fields();
        test_read_only();
        test_pin_and_mute();
        give_verdict();
    end

    // about 7000 cycles expected; the limit allows roughly three times that
    initial begin
        #500000;
        bad_count++;
        give_verdict();
    end
endmodule
